// file: extended_mem_op_execute_tb_top.sv
/*
  Bench of the execute unit: one table line per operation case.
  Assumes xme_mem_model holds the operand at data address 5.
*/
`timescale 1ns/1ps
`default_nettype none
module extended_mem_op_execute_tb_top;
  // ========
  // Signals
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic start_i = 1'b0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  xme_pkg::xme_op_t op_i = xme_pkg::OP_FILL_ONES;
  logic [9:0] addr_i = 10'h005; // Operand always at address 5
  logic [7:0] operand_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [2:0] bitsel_i = 3'h0;
  logic [2:0] reg_addr_i = 3'h0;
  logic busy_o, done_o, skip_o, mem_we_o, prog_re_o;
  logic [9:0] mem_addr_o;
  logic [7:0] mem_wdata_o, reg_rdata_o, acc_o, table_read_high_latch_o;
  logic [5:0] flags_o;
  logic [13:0] prog_addr_o;
  logic [15:0] prog_data_i;
  int bad_count = 0;
  int checks = 0;
  // Case: op a m exp_m exp_a flags exp_flags exp_latch {bit, skip}
  logic [67:0] tbl [27] = '{
    68'h00_05040005_2027_00_0,
    68'h0C_102020F0_0012_00_0,
    68'h0D_80017F80_0019_00_0,
    68'h01_11010011_2A2A_00_1,
    68'h01_1100FF11_2A2A_00_0,
    68'h02_11010100_2A2A_00_1,
    68'h03_115AFF11_2A2A_00_0,
    68'h04_11008011_2A2A_00_E,
    68'h05_11FF0011_2A2A_00_1,
    68'h06_11FEFEFF_2A2A_00_0,
    68'h07_11080811_2A2A_00_7,
    68'h07_11080811_2A2A_00_4,
    68'h08_11010111_2A2A_00_1,
    68'h08_11000011_2A2A_00_0,
    68'h09_11F7F711_2A2A_00_7,
    68'h0A_11000011_2A2A_00_1,
    68'h0A_11050511_2A2A_00_0,
    68'h0B_11000000_2A2A_00_1,
    68'h0B_119C9C9C_2A2A_00_0,
    68'h0E_11122111_2A2A_00_0,
    68'h0F_11343443_2A2A_00_0,
    68'h14_0FF0F0FF_2E2A_00_0,
    68'h15_3C3C003C_2A2E_00_0,
    68'h10_1100FF11_2A2A_92_0,
    68'h11_1100FF11_2A2A_BF_0,
    68'h12_11000011_2A2A_92_0,
    68'h13_11000111_2A2A_BF_0};
  always #2.5 clk_i = ~clk_i; // 200 MHz
  xme_exec dut (.clk_i, .reset_n_i, .start_i, .op_i, .addr_i, .operand_i, .bitsel_i,
    .busy_o, .done_o, .skip_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .prog_re_o,
    .prog_addr_o, .prog_data_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o, .acc_o, .flags_o, .table_read_high_latch_o);
  xme_mem_model mdl (.clk_i, .we_i(mem_we_o), .waddr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .re_i(prog_re_o), .paddr_i(prog_addr_o), .pdata_o(prog_data_i));
  // ========
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask : reg_rd
  // Preset state, issue one request, then check timing and every result
  task automatic do_op(input logic [67:0] t);
    int n;
    reg_wr(xme_pkg::REG_ACC, t[59:52]);
    reg_wr(xme_pkg::REG_STATUS, t[27:20]);
    mdl.mem[5] = t[51:44];
    @(posedge clk_i);
    start_i <= 1'b1;
    op_i <= xme_pkg::xme_op_t'(t[64:60]);
    operand_i <= t[51:44];
    bitsel_i <= t[3:1];
    @(posedge clk_i);
    start_i <= 1'b0;
    n = 1;
    #1;
    chk({7'h0, busy_o}, 8'h01);
    while (done_o !== 1'b1 && n < 9) begin
      @(posedge clk_i);
      n++;
      #1;
    end
    if (n == 9) begin
      $display("[ERR] %0t no completion pulse", $time);
      bad_count++;
      end_sim();
    end
    chk(8'(n), 8'(2 + t[0]));
    chk({7'h0, skip_o}, {7'h0, t[0]});
    chk({7'h0, busy_o}, 8'h00);
    chk(acc_o, t[35:28]);
    chk({2'h0, flags_o}, t[19:12]);
    chk(table_read_high_latch_o, t[11:4]);
    @(posedge clk_i);
    #1 chk(mdl.mem[5], t[43:36]);
  endtask : do_op
  // ========
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) reg_rd(3'(i), 8'h00); // All zero, unmapped too
    reg_wr(xme_pkg::REG_TBL_LATCH, 8'h77); // Read-only, must not stick
    reg_rd(xme_pkg::REG_TBL_LATCH, 8'h00);
    reg_wr(xme_pkg::REG_TBL_LOW, 8'hFF);
    reg_wr(xme_pkg::REG_TBL_HIGH, 8'h12);
    $display("test registers done");
    for (int i = 0; i < 27; i++) begin
      do_op(tbl[i]);
      $display("test case %0d done", i);
    end
    reg_rd(xme_pkg::REG_TBL_LOW, 8'h01);
    // Mid-run reset must clear every piece of core state
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1 chk(acc_o, 8'h00);
    chk({2'h0, flags_o}, 8'h00);
    chk(table_read_high_latch_o, 8'h00);
    reg_rd(xme_pkg::REG_TBL_LOW, 8'h00);
    $display("test reset done");
    end_sim();
  end
endmodule : extended_mem_op_execute_tb_top
`default_nettype wire

// file: xme_alu.sv
/*
  Combinational ALU for the extended memory operations.
  Assumes operands are stable for the whole execute cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module xme_alu (
  // Operand and result bundle
  xme_alu_if.alu bus
);
  // ==========================================================
  // Result computation
  // ==========================================================
  logic borrow; // Borrow-in, only the chained form uses it
  logic [8:0] diff; // Full difference with borrow-out in bit 8
  logic [4:0] hdiff; // Low nibble difference for the half carry
  logic [5:0] sflags; // Flags after a subtraction
  logic [7:0] mask; // One-hot bit select

  always_comb begin
    borrow = (bus.op == xme_pkg::OP_SUB_BORROW_TO_MEM) ? ~bus.flags[xme_pkg::F_CARRY] : 1'b0;
    diff = {1'b0, bus.acc} - {1'b0, bus.mem} - {8'h00, borrow};
    hdiff = {1'b0, bus.acc[3:0]} - {1'b0, bus.mem[3:0]} - {4'h0, borrow};
    mask = xme_pkg::ONE << bus.bitsel;
    sflags = bus.flags;
    // Carry is the inverted borrow: cleared on a negative result
    sflags[xme_pkg::F_CARRY] = ~diff[8];
    sflags[xme_pkg::F_HALF] = ~hdiff[4];
    sflags[xme_pkg::F_ZERO] = (diff[7:0] == 8'h00);
    sflags[xme_pkg::F_EXCESS] = (bus.acc[7] ^ bus.mem[7]) & (diff[7] ^ bus.acc[7]);
    // Signed carry is the true sign, valid even on overflow
    sflags[xme_pkg::F_SCARRY] = sflags[xme_pkg::F_EXCESS] ^ diff[7];
    // Chained zero keeps history only in the borrow form
    sflags[xme_pkg::F_CZERO] = (borrow || bus.op == xme_pkg::OP_SUB_BORROW_TO_MEM) ?
      (sflags[xme_pkg::F_ZERO] & bus.flags[xme_pkg::F_CZERO]) : sflags[xme_pkg::F_ZERO];
    // Defaults: nothing written, flags held
    bus.acc_we = 1'b0;
    bus.acc_res = bus.acc;
    bus.mem_we = 1'b0;
    bus.mem_res = bus.mem;
    bus.flags_res = bus.flags;
    bus.skip = 1'b0;
    bus.latch_we = 1'b0;
    case (bus.op)
      xme_pkg::OP_SUB_BORROW_TO_MEM, xme_pkg::OP_SUBTRACT_INTO_MEM: begin
        bus.mem_we = 1'b1;
        bus.mem_res = diff[7:0];
        bus.flags_res = sflags;
      end
      xme_pkg::OP_SUBTRACT_PLAIN: begin
        bus.acc_we = 1'b1;
        bus.acc_res = diff[7:0];
        bus.flags_res = sflags;
      end
      xme_pkg::OP_DEC_SKIP_ZERO: begin
        bus.mem_we = 1'b1;
        bus.mem_res = bus.mem - xme_pkg::ONE;
        bus.skip = (bus.mem_res == 8'h00);
      end
      xme_pkg::OP_DEC_SKIP_ZERO_TO_A: begin
        bus.acc_we = 1'b1;
        bus.acc_res = bus.mem - xme_pkg::ONE;
        bus.skip = (bus.acc_res == 8'h00);
      end
      xme_pkg::OP_INC_SKIP_ZERO: begin
        bus.mem_we = 1'b1;
        bus.mem_res = bus.mem + xme_pkg::ONE;
        bus.skip = (bus.mem_res == 8'h00);
      end
      xme_pkg::OP_INC_SKIP_ZERO_TO_A: begin
        bus.acc_we = 1'b1;
        bus.acc_res = bus.mem + xme_pkg::ONE;
        bus.skip = (bus.acc_res == 8'h00);
      end
      xme_pkg::OP_FILL_ONES: begin
        bus.mem_we = 1'b1;
        bus.mem_res = xme_pkg::ALL_ONES;
      end
      xme_pkg::OP_SET_BIT: begin
        bus.mem_we = 1'b1;
        bus.mem_res = bus.mem | mask;
      end
      // Bit tests touch no memory
      xme_pkg::OP_SKIP_BIT_NONZERO: bus.skip = |(bus.mem & mask);
      xme_pkg::OP_SKIP_BIT_ZERO: bus.skip = ~|(bus.mem & mask);
      // Byte tests write the byte back unchanged
      xme_pkg::OP_SKIP_NONZERO: begin
        bus.mem_we = 1'b1;
        bus.skip = (bus.mem != 8'h00);
      end
      xme_pkg::OP_SKIP_ZERO_TEST: begin
        bus.mem_we = 1'b1;
        bus.skip = (bus.mem == 8'h00);
      end
      xme_pkg::OP_COPY_SKIP_ZERO: begin
        bus.acc_we = 1'b1;
        bus.acc_res = bus.mem;
        bus.skip = (bus.mem == 8'h00);
      end
      xme_pkg::OP_NIBBLE_EXCHANGE: begin
        bus.mem_we = 1'b1;
        bus.mem_res = {bus.mem[3:0], bus.mem[7:4]};
      end
      xme_pkg::OP_NIBBLE_EXCHANGE_TO_A: begin
        bus.acc_we = 1'b1;
        bus.acc_res = {bus.mem[3:0], bus.mem[7:4]};
      end
      xme_pkg::OP_TABLE_FETCH_PAGED, xme_pkg::OP_TABLE_FETCH_LAST_PAGE,
      xme_pkg::OP_PREINC_TABLE_FETCH_PAGED, xme_pkg::OP_PREINC_TABLE_FETCH_LAST: begin
        bus.mem_we = 1'b1;
        bus.mem_res = bus.tdata[7:0];
        bus.latch_we = 1'b1;
      end
      xme_pkg::OP_XOR_INTO_A: begin
        bus.acc_we = 1'b1;
        bus.acc_res = bus.acc ^ bus.mem;
        bus.flags_res[xme_pkg::F_ZERO] = ((bus.acc ^ bus.mem) == 8'h00);
      end
      xme_pkg::OP_XOR_INTO_MEM: begin
        bus.mem_we = 1'b1;
        bus.mem_res = bus.acc ^ bus.mem;
        bus.flags_res[xme_pkg::F_ZERO] = ((bus.acc ^ bus.mem) == 8'h00);
      end
      default: bus.skip = 1'b0;
    endcase
  end
endmodule : xme_alu
`default_nettype wire

// file: xme_alu_if.sv
/*
  Operand and result bundle between the execute sequencer and its ALU.
  Assumes both ends sit in the same clock domain; the bundle is combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface xme_alu_if;
  // Operands
  xme_pkg::xme_op_t op;
  logic [7:0] acc;
  logic [7:0] mem;
  logic [2:0] bitsel;
  logic [5:0] flags;
  logic [15:0] tdata;
  // Results
  logic acc_we;
  logic [7:0] acc_res;
  logic mem_we;
  logic [7:0] mem_res;
  logic [5:0] flags_res;
  logic skip;
  logic latch_we;

  modport core (output op, acc, mem, bitsel, flags, tdata,
                input acc_we, acc_res, mem_we, mem_res, flags_res, skip, latch_we);
  modport alu (input op, acc, mem, bitsel, flags, tdata,
               output acc_we, acc_res, mem_we, mem_res, flags_res, skip, latch_we);
endinterface : xme_alu_if
`default_nettype wire

// file: xme_exec.sv
/*
  Execute unit for extended data-memory operations: subtraction, skip
  tests, set, swap, table fetch and XOR, with accumulator, flags and
  table pointer registers.
  Assumes the sequencer offers the memory operand with the start pulse and
  the program memory answers in the same cycle as its read strobe.
*/
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module xme_exec #(
  parameter int MEM_AW = 10, // Data memory address width
  parameter int PROG_AW = 14 // Program memory address width
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Instruction request from the sequencer
  input wire logic start_i,
  input wire xme_pkg::xme_op_t op_i,
  input wire logic [MEM_AW-1:0] addr_i,
  input wire logic [7:0] operand_i,
  input wire logic [2:0] bitsel_i,
  // Completion
  output logic busy_o,
  output logic done_o,
  output logic skip_o,
  // Data memory write
  output logic mem_we_o,
  output logic [MEM_AW-1:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  // Program memory read
  output logic prog_re_o,
  output logic [PROG_AW-1:0] prog_addr_o,
  input wire logic [15:0] prog_data_i,
  // Register port
  input wire logic [xme_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // Core state
  output logic [7:0] acc_o,
  output logic [5:0] flags_o,
  output logic [7:0] table_read_high_latch_o
);
  localparam int HP_W = PROG_AW - 8; // Width of the high table pointer

  // ==========================================================
  // Decode helpers
  // ==========================================================
  // Any of the four table fetch forms
  function automatic logic is_table(input xme_pkg::xme_op_t op);
    is_table = (op == xme_pkg::OP_TABLE_FETCH_PAGED) ||
      (op == xme_pkg::OP_TABLE_FETCH_LAST_PAGE) ||
      (op == xme_pkg::OP_PREINC_TABLE_FETCH_PAGED) ||
      (op == xme_pkg::OP_PREINC_TABLE_FETCH_LAST);
  endfunction : is_table

  // Forms that bump the low pointer first
  function automatic logic is_preinc(input xme_pkg::xme_op_t op);
    is_preinc = (op == xme_pkg::OP_PREINC_TABLE_FETCH_PAGED) ||
      (op == xme_pkg::OP_PREINC_TABLE_FETCH_LAST);
  endfunction : is_preinc

  // Forms that address the last program page
  function automatic logic is_last(input xme_pkg::xme_op_t op);
    is_last = (op == xme_pkg::OP_TABLE_FETCH_LAST_PAGE) ||
      (op == xme_pkg::OP_PREINC_TABLE_FETCH_LAST);
  endfunction : is_last

  // ==========================================================
  // State
  // ==========================================================
  xme_pkg::xme_state_t state_q, state_d; // Sequencer
  xme_pkg::xme_op_t op_q, op_d; // Latched operation
  logic [7:0] opnd_q, opnd_d; // Latched memory operand
  logic [2:0] bit_q, bit_d; // Latched bit select
  logic [7:0] acc_q, acc_d; // Accumulator
  logic [5:0] flags_q, flags_d; // Status flags
  logic [7:0] tp_lo_q, tp_lo_d; // Low table pointer
  logic [HP_W-1:0] tp_hi_q, tp_hi_d; // High table pointer
  logic [7:0] hi_latch_q, hi_latch_d; // Table read high latch
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic skip_q, skip_d;
  logic mem_we_q, mem_we_d;
  logic [MEM_AW-1:0] maddr_q, maddr_d; // Operand address, reused for write
  logic [7:0] mwd_q, mwd_d;
  logic pre_q, pre_d;
  logic [PROG_AW-1:0] padr_q, padr_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] lp_next; // Low pointer as the fetch will use it

  xme_alu_if alu_bus ();

  // ==========================================================
  // ALU hookup: operands come from latched state, table data straight from prog_data_i
  // ==========================================================
  assign alu_bus.op = op_q;
  assign alu_bus.acc = acc_q;
  assign alu_bus.mem = opnd_q;
  assign alu_bus.bitsel = bit_q;
  assign alu_bus.flags = flags_q;
  assign alu_bus.tdata = prog_data_i;

  xme_alu u_alu (
    .bus(alu_bus)
  );

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    opnd_d = opnd_q;
    bit_d = bit_q;
    acc_d = acc_q;
    flags_d = flags_q;
    tp_lo_d = tp_lo_q;
    tp_hi_d = tp_hi_q;
    hi_latch_d = hi_latch_q;
    done_d = 1'b0;
    skip_d = 1'b0;
    mem_we_d = 1'b0;
    maddr_d = maddr_q;
    mwd_d = mwd_q;
    pre_d = 1'b0;
    padr_d = padr_q;
    lp_next = is_preinc(op_i) ? tp_lo_q + xme_pkg::ONE : tp_lo_q;
    // Register port writes; the execute path below overrides them
    if (reg_we_i) begin
      case (reg_addr_i)
        xme_pkg::REG_ACC: acc_d = reg_wdata_i;
        xme_pkg::REG_STATUS: flags_d = reg_wdata_i[5:0];
        xme_pkg::REG_TBL_LOW: tp_lo_d = reg_wdata_i;
        xme_pkg::REG_TBL_HIGH: tp_hi_d = reg_wdata_i[HP_W-1:0];
        default: acc_d = acc_d; // Latch and unmapped ignore writes
      endcase
    end
    case (state_q)
      xme_pkg::ST_IDLE: begin
        // Take a request; a table form also starts its fetch at once
        if (start_i) begin
          op_d = op_i;
          opnd_d = operand_i;
          bit_d = bitsel_i;
          maddr_d = addr_i;
          state_d = xme_pkg::ST_EXEC;
          if (is_table(op_i)) begin
            tp_lo_d = lp_next;
            pre_d = 1'b1;
            // Last page: upper address bits all ones
            padr_d = is_last(op_i) ? {{HP_W{1'b1}}, lp_next} : {tp_hi_q, lp_next};
          end
        end
      end
      xme_pkg::ST_EXEC: begin
        // Commit results; a taken skip inserts the dummy cycle
        if (alu_bus.acc_we) begin
          acc_d = alu_bus.acc_res;
        end
        if (alu_bus.latch_we) begin
          hi_latch_d = prog_data_i[15:8];
        end
        flags_d = alu_bus.flags_res;
        mem_we_d = alu_bus.mem_we;
        mwd_d = alu_bus.mem_res;
        if (alu_bus.skip) begin
          state_d = xme_pkg::ST_DUMMY;
        end else begin
          state_d = xme_pkg::ST_IDLE;
          done_d = 1'b1;
        end
      end
      xme_pkg::ST_DUMMY: begin
        // Dummy fetch slot ends the skipping instruction
        state_d = xme_pkg::ST_IDLE;
        done_d = 1'b1;
        skip_d = 1'b1;
      end
      default: state_d = xme_pkg::ST_IDLE;
    endcase
    busy_d = (state_d != xme_pkg::ST_IDLE);
    // Read data stand only in the cycle after the strobe
    rdata_d = 8'h00;
    if (reg_re_i) begin
      case (reg_addr_i)
        xme_pkg::REG_ACC: rdata_d = acc_q;
        xme_pkg::REG_STATUS: rdata_d = {2'b00, flags_q};
        xme_pkg::REG_TBL_LOW: rdata_d = tp_lo_q;
        xme_pkg::REG_TBL_HIGH: rdata_d = {{(8-HP_W){1'b0}}, tp_hi_q};
        xme_pkg::REG_TBL_LATCH: rdata_d = hi_latch_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= xme_pkg::ST_IDLE;
      op_q <= xme_pkg::OP_SUB_BORROW_TO_MEM;
      opnd_q <= xme_pkg::RST_BYTE;
      bit_q <= 3'h0;
      acc_q <= xme_pkg::RST_ACC;
      flags_q <= xme_pkg::RST_FLAGS;
      tp_lo_q <= xme_pkg::RST_BYTE;
      tp_hi_q <= '0;
      hi_latch_q <= xme_pkg::RST_BYTE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      skip_q <= 1'b0;
      mem_we_q <= 1'b0;
      maddr_q <= '0;
      mwd_q <= xme_pkg::RST_BYTE;
      pre_q <= 1'b0;
      padr_q <= '0;
      rdata_q <= xme_pkg::RST_BYTE;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      opnd_q <= opnd_d;
      bit_q <= bit_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      tp_lo_q <= tp_lo_d;
      tp_hi_q <= tp_hi_d;
      hi_latch_q <= hi_latch_d;
      busy_q <= busy_d;
      done_q <= done_d;
      skip_q <= skip_d;
      mem_we_q <= mem_we_d;
      maddr_q <= maddr_d;
      mwd_q <= mwd_d;
      pre_q <= pre_d;
      padr_q <= padr_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flops
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign skip_o = skip_q;
  assign mem_we_o = mem_we_q;
  assign mem_addr_o = maddr_q;
  assign mem_wdata_o = mwd_q;
  assign prog_re_o = pre_q;
  assign prog_addr_o = padr_q;
  assign reg_rdata_o = rdata_q;
  assign acc_o = acc_q;
  assign flags_o = flags_q;
  assign table_read_high_latch_o = hi_latch_q;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Reference values built independently of the ALU
  logic ex;
  logic [8:0] h_sbc;
  logic [8:0] h_sub;
  logic [7:0] h_dec;
  logic [7:0] h_inc;
  logic h_bit;
  logic [7:0] h_hi;
  assign ex = (state_q == xme_pkg::ST_EXEC);
  assign h_sbc = {1'b0, acc_q} - {1'b0, opnd_q} - {8'h00, !flags_q[xme_pkg::F_CARRY]};
  assign h_sub = {1'b0, acc_q} - {1'b0, opnd_q};
  assign h_dec = opnd_q - xme_pkg::ONE;
  assign h_inc = opnd_q + xme_pkg::ONE;
  assign h_bit = opnd_q[bit_q];
  assign h_hi = prog_data_i[15:8];

  sbc_result_a: assert property (ex && op_q == xme_pkg::OP_SUB_BORROW_TO_MEM |=>
    mem_we_o && mem_wdata_o == $past(h_sbc[7:0]) && flags_o[0] == !$past(h_sbc[8]))
    else $error("borrow subtract result or carry wrong");
  skip_time_a: assert property (state_q == xme_pkg::ST_IDLE && start_i |-> ##2
    ((done_o && !skip_o) || state_q == xme_pkg::ST_DUMMY))
    else $error("instruction length wrong");
  dummy_done_a: assert property (state_q == xme_pkg::ST_DUMMY |=> done_o && skip_o)
    else $error("dummy cycle not closed by skip");
  dec_mem_a: assert property (ex && op_q == xme_pkg::OP_DEC_SKIP_ZERO |=>
    mem_wdata_o == $past(h_dec) && $stable(flags_o) &&
    (state_q == xme_pkg::ST_DUMMY) == (mem_wdata_o == 8'h00))
    else $error("decrement skip wrong");
  dec_acc_a: assert property (ex && op_q == xme_pkg::OP_DEC_SKIP_ZERO_TO_A |=>
    acc_o == $past(h_dec) && !mem_we_o && (state_q == xme_pkg::ST_DUMMY) == (acc_o == 8'h00))
    else $error("decrement to accumulator wrong");
  fill_ones_a: assert property (ex && op_q == xme_pkg::OP_FILL_ONES |=>
    mem_we_o && mem_wdata_o == 8'hFF && $stable(flags_o))
    else $error("fill with ones wrong");
  set_bit_a: assert property (ex && op_q == xme_pkg::OP_SET_BIT |=>
    mem_wdata_o == ($past(opnd_q) | (8'h01 << $past(bit_q))) && $stable(flags_o))
    else $error("bit set wrong");
  inc_mem_a: assert property (ex && op_q == xme_pkg::OP_INC_SKIP_ZERO |=>
    mem_wdata_o == $past(h_inc) && (state_q == xme_pkg::ST_DUMMY) == (mem_wdata_o == 8'h00))
    else $error("increment skip wrong");
  bit_nz_a: assert property (ex && op_q == xme_pkg::OP_SKIP_BIT_NONZERO |=>
    (state_q == xme_pkg::ST_DUMMY) == $past(h_bit) && !mem_we_o)
    else $error("bit nonzero skip wrong");
  zero_test_a: assert property (ex && op_q == xme_pkg::OP_SKIP_ZERO_TEST |=>
    mem_we_o && mem_wdata_o == $past(opnd_q) &&
    (state_q == xme_pkg::ST_DUMMY) == (mem_wdata_o == 8'h00))
    else $error("byte zero skip wrong");
  sub_plain_a: assert property (ex && op_q == xme_pkg::OP_SUBTRACT_PLAIN |=>
    acc_o == $past(h_sub[7:0]) && flags_o[0] == !$past(h_sub[8]) && !mem_we_o)
    else $error("plain subtract wrong");
  swap_mem_a: assert property (ex && op_q == xme_pkg::OP_NIBBLE_EXCHANGE |=>
    mem_wdata_o == {$past(opnd_q[3:0]), $past(opnd_q[7:4])})
    else $error("nibble swap wrong");
  table_hi_a: assert property (ex && op_q == xme_pkg::OP_TABLE_FETCH_PAGED |=>
    table_read_high_latch_o == $past(h_hi) && mem_we_o)
    else $error("table high latch wrong");
  xor_acc_a: assert property (ex && op_q == xme_pkg::OP_XOR_INTO_A |=>
    acc_o == ($past(acc_q) ^ $past(opnd_q)) && flags_o[2] == (acc_o == 8'h00))
    else $error("xor to accumulator wrong");

  skip_seen_c: cover property (state_q == xme_pkg::ST_DUMMY ##1 done_o);
  table_preinc_c: cover property (ex && op_q == xme_pkg::OP_PREINC_TABLE_FETCH_LAST);
  sbc_negative_c: cover property (ex && op_q == xme_pkg::OP_SUB_BORROW_TO_MEM && h_sbc[8]);
  back_to_back_c: cover property (done_o && start_i);
endmodule : xme_exec
`default_nettype wire

// file: xme_mem_model.sv
/*
  Memory partner of the execute unit: data bytes and program words.
  Assumes writes land on the rising edge and program reads answer at once.
*/
`timescale 1ns/1ps
`default_nettype none
module xme_mem_model (
  // Clock
  input wire logic clk_i,
  // Data memory write
  input wire logic we_i,
  input wire logic [9:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // Program memory read
  input wire logic re_i,
  input wire logic [13:0] paddr_i,
  output logic [15:0] pdata_o
);
  // ========
  // Storage
  logic [7:0] mem [1024]; // Bench pokes operands here
  // Word holds its own address so a wrong fetch shows; idle bus is inverted
  assign pdata_o = re_i ? {2'h2, paddr_i} : ~{2'h2, paddr_i};
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
endmodule : xme_mem_model
`default_nettype wire

// file: xme_pkg.sv
/*
  Shared constants and types of the extended memory-operation execute unit.
  Assumes an 8-bit data path and a 16-bit program word.
*/
`default_nettype none
package xme_pkg;
  // ==========================================================
  // Operations
  // ==========================================================
  typedef enum logic [4:0] {
    OP_SUB_BORROW_TO_MEM, OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_TO_A,
    OP_FILL_ONES, OP_SET_BIT, OP_INC_SKIP_ZERO, OP_INC_SKIP_ZERO_TO_A,
    OP_SKIP_BIT_NONZERO, OP_SKIP_NONZERO, OP_SKIP_BIT_ZERO,
    OP_SKIP_ZERO_TEST, OP_COPY_SKIP_ZERO, OP_SUBTRACT_PLAIN,
    OP_SUBTRACT_INTO_MEM, OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_TO_A,
    OP_TABLE_FETCH_PAGED, OP_TABLE_FETCH_LAST_PAGE,
    OP_PREINC_TABLE_FETCH_PAGED, OP_PREINC_TABLE_FETCH_LAST,
    OP_XOR_INTO_A, OP_XOR_INTO_MEM
  } xme_op_t;

  // Sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DUMMY} xme_state_t;

  // ==========================================================
  // Status flag positions
  // ==========================================================
  localparam int FLAG_W = 6;
  localparam int F_CARRY = 0;
  localparam int F_HALF = 1;
  localparam int F_ZERO = 2;
  localparam int F_EXCESS = 3;
  localparam int F_SCARRY = 4;
  localparam int F_CZERO = 5;

  // ==========================================================
  // Register port map (8-bit registers)
  // ==========================================================
  localparam int REG_AW = 3;
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_TBL_LOW = 3'h2;
  localparam logic [2:0] REG_TBL_HIGH = 3'h3;
  localparam logic [2:0] REG_TBL_LATCH = 3'h4;

  // Values after reset
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [5:0] RST_FLAGS = 6'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Data constants
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ONE = 8'h01;
endpackage : xme_pkg
`default_nettype wire
